/* File: hw/pmic_output_discharge_config.sv */
/*
  Output discharge enables, LED boost overvoltage code, spare register
  and channel 3/2 power-on delay registers with their channel logic.
  Assumes the sequencer drives turn-on requests and channel running flags,
  synchronous to mclk, and a host on the two-wire serial pins.
*/
// Functional notes
// - Channel 10 output is pulled down while off if its bit is 1; resets 0.
// - Channel 5 output is pulled down while off if its bit is 1; resets 1.
// - Channel 4 output is pulled down while off if its bit is 1; resets 1.
// - Channel 3 output is pulled down while off if its bit is 1; resets 1.
module pmic_output_discharge_config
  import pmic_cfg_pkg::*;
#(
  parameter int         DELAY_UNIT_CYCLES = DLY_UNIT_CYC,
  parameter logic [6:0] DEV_ADDR          = DEV_ADDR_DEFAULT
)
(
  // Clock and reset
  input  wire logic                 mclk,
  input  wire logic                 rst_b,
  // Serial pins
  input  wire logic                 scl_i,
  input  wire logic                 sda_i,
  output      logic                 sda_o,
  output      logic                 sda_oe,
  // Sequencer side
  input  wire logic [1:0]           power_sequence_selection,
  input  wire pmic_cfg_pkg::disch_s ch_running,
  input  wire logic                 ch3_on_req,
  input  wire logic                 ch2_on_req,
  // Channel controls
  output      pmic_cfg_pkg::disch_s ch_pulldown,
  output      logic                 ch3_enable,
  output      logic                 ch2_enable,
  output      logic [2:0]           led_boost_overvoltage_code
);
  import pmic_cfg_pkg::*;

  reg_wr_s    wr;
  logic [7:0] rd_addr;
  logic [7:0] rd_data;
  logic       sda_o_c;
  logic       sda_oe_c;

  logic       ch10_output_pulldown_enable_q;
  logic       ch5_output_pulldown_enable_q;
  logic       ch4_output_pulldown_enable_q;
  logic       ch3_output_pulldown_enable_q;
  logic [2:0] ovp_q;
  logic [3:0] ch3_turn_on_delay_code_q;
  logic [3:0] ch2_turn_on_delay_code_q;
  logic       sda_oe_q;
  disch_s     pd_q;

  pwr_e                 pst_q [2];
  logic [DLY_CNT_W-1:0] dcnt_q [2];
  logic [3:0]           code_lat_q [2];
  logic [1:0]           on_q;
  logic [1:0]           req;
  logic [3:0]           code [2];

  function automatic logic [DLY_CNT_W-1:0] dly_cycles(input logic [3:0] c);
    dly_cycles = DLY_CNT_W'(int'(c) * DELAY_UNIT_CYCLES);
  endfunction

  assign req     = {ch3_on_req, ch2_on_req};
  assign code[0] = ch2_turn_on_delay_code_q;
  assign code[1] = ch3_turn_on_delay_code_q;

  // ----------------------------------------------------------------
  // Serial slave
  // ----------------------------------------------------------------
  serial_reg_slave #(
    .DEV_ADDR (DEV_ADDR)
  ) u_slave (
    .mclk    (mclk),
    .rst_b   (rst_b),
    .scl_i   (scl_i),
    .sda_i   (sda_i),
    .sda_o   (sda_o_c),
    .sda_oe  (sda_oe_c),
    .wr      (wr),
    .rd_addr (rd_addr),
    .rd_data (rd_data)
  );

  always_ff @(posedge mclk)
  begin
    sda_oe_q <= rst_b & sda_oe_c;
    sda_o    <= sda_o_c;
  end
  assign sda_oe = sda_oe_q;

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      ch10_output_pulldown_enable_q <= RST_DISCHARGE[DIS_CH10_POS];
      ch5_output_pulldown_enable_q  <= RST_DISCHARGE[DIS_CH5_POS];
      ch4_output_pulldown_enable_q  <= RST_DISCHARGE[DIS_CH4_POS];
      ch3_output_pulldown_enable_q  <= RST_DISCHARGE[DIS_CH3_POS];
      ovp_q                         <= RST_LED_OVP[OVP_LSB +: OVP_W];
      ch3_turn_on_delay_code_q      <=
        RST_ON_DLY_SEQ[power_sequence_selection][DLY_CH3_LSB +: DLY_W];
      ch2_turn_on_delay_code_q      <=
        RST_ON_DLY_SEQ[power_sequence_selection][DLY_CH2_LSB +: DLY_W];
    end
    else if (wr.en)
    begin
      if (wr.addr == OFS_DISCHARGE)
      begin
        ch10_output_pulldown_enable_q <= wr.data[DIS_CH10_POS];
        ch5_output_pulldown_enable_q  <= wr.data[DIS_CH5_POS];
        ch4_output_pulldown_enable_q  <= wr.data[DIS_CH4_POS];
        ch3_output_pulldown_enable_q  <= wr.data[DIS_CH3_POS];
      end
      if (wr.addr == OFS_LED_OVP)
        ovp_q <= wr.data[OVP_LSB +: OVP_W];
      if (wr.addr == OFS_ON_DLY_3_2)
      begin
        ch3_turn_on_delay_code_q <= wr.data[DLY_CH3_LSB +: DLY_W];
        ch2_turn_on_delay_code_q <= wr.data[DLY_CH2_LSB +: DLY_W];
      end
    end
  end

  // ----------------------------------------------------------------
  // Register reads
  // ----------------------------------------------------------------
  always_comb
  begin
    rd_data = 8'h00;
    unique case (rd_addr)
      OFS_DISCHARGE:
      begin
        rd_data[DIS_CH10_POS] = ch10_output_pulldown_enable_q;
        rd_data[DIS_CH5_POS]  = ch5_output_pulldown_enable_q;
        rd_data[DIS_CH4_POS]  = ch4_output_pulldown_enable_q;
        rd_data[DIS_CH3_POS]  = ch3_output_pulldown_enable_q;
      end
      OFS_LED_OVP:    rd_data[OVP_LSB +: OVP_W] = ovp_q;
      OFS_SPARE:      rd_data = RST_SPARE;
      OFS_ON_DLY_3_2: rd_data = {ch3_turn_on_delay_code_q, ch2_turn_on_delay_code_q};
      default:        rd_data = 8'h00;
    endcase
  end

  // ----------------------------------------------------------------
  // Output discharge
  // ----------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      pd_q <= '0;
      led_boost_overvoltage_code <= RST_LED_OVP[OVP_LSB +: OVP_W];
    end
    else
    begin
      pd_q.ch10 <= ch10_output_pulldown_enable_q & ~ch_running.ch10;
      pd_q.ch5  <= ch5_output_pulldown_enable_q & ~ch_running.ch5;
      pd_q.ch4  <= ch4_output_pulldown_enable_q & ~ch_running.ch4;
      pd_q.ch3  <= ch3_output_pulldown_enable_q & ~ch_running.ch3;
      led_boost_overvoltage_code <= ovp_q;
    end
  end
  assign ch_pulldown = pd_q;

  // ----------------------------------------------------------------
  // Turn-on delay, index 0 is channel 2, index 1 is channel 3
  // ----------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    for (int i = 0; i < 2; i++)
    begin
      if (!rst_b)
      begin
        pst_q[i]      <= PWR_OFF;
        dcnt_q[i]     <= '0;
        code_lat_q[i] <= 4'h0;
        on_q[i]       <= 1'b0;
      end
      else
      begin
        unique case (pst_q[i])
          PWR_OFF:
            if (req[i])
            begin
              code_lat_q[i] <= code[i];
              if (code[i] == 4'h0)
              begin
                pst_q[i] <= PWR_ON;
                on_q[i]  <= 1'b1;
              end
              else
              begin
                pst_q[i]  <= PWR_WAIT;
                dcnt_q[i] <= dly_cycles(code[i]) - DLY_CNT_W'(1);
              end
            end
          PWR_WAIT:
            if (!req[i])
              pst_q[i] <= PWR_OFF;
            else if (dcnt_q[i] == '0)
            begin
              pst_q[i] <= PWR_ON;
              on_q[i]  <= 1'b1;
            end
            else
              dcnt_q[i] <= dcnt_q[i] - DLY_CNT_W'(1);
          PWR_ON:
            if (!req[i])
            begin
              pst_q[i] <= PWR_OFF;
              on_q[i]  <= 1'b0;
            end
          default: pst_q[i] <= PWR_OFF;
        endcase
      end
    end
  end
  assign ch2_enable = on_q[0];
  assign ch3_enable = on_q[1];

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [DLY_CNT_W-1:0] elapsed_q [2];

  always_ff @(posedge mclk)
  begin
    for (int i = 0; i < 2; i++)
      elapsed_q[i] <= (rst_b && req[i] && !on_q[i]) ? elapsed_q[i] + DLY_CNT_W'(1) : '0;
  end

  a_ch10_pulldown_follow: assert property (
    @(posedge mclk) disable iff (!rst_b)
    $past(rst_b) |-> pd_q.ch10 == $past(ch10_output_pulldown_enable_q && !ch_running.ch10))
    else $error("ch10 pulldown mismatch");
  a_ch5_pulldown_follow: assert property (
    @(posedge mclk) disable iff (!rst_b)
    $past(rst_b) |-> pd_q.ch5 == $past(ch5_output_pulldown_enable_q && !ch_running.ch5))
    else $error("ch5 pulldown mismatch");
  a_ch4_pulldown_follow: assert property (
    @(posedge mclk) disable iff (!rst_b)
    $past(rst_b) |-> pd_q.ch4 == $past(ch4_output_pulldown_enable_q && !ch_running.ch4))
    else $error("ch4 pulldown mismatch");
  a_ch3_pulldown_follow: assert property (
    @(posedge mclk) disable iff (!rst_b)
    $past(rst_b) |-> pd_q.ch3 == $past(ch3_output_pulldown_enable_q && !ch_running.ch3))
    else $error("ch3 pulldown mismatch");
  a_discharge_reset_value: assert property (
    @(posedge mclk)
    $rose(rst_b) |-> {ch10_output_pulldown_enable_q, ch5_output_pulldown_enable_q,
                      ch4_output_pulldown_enable_q, ch3_output_pulldown_enable_q} == 4'b0111)
    else $error("discharge enables wrong after reset");
  a_discharge_write_lands: assert property (
    @(posedge mclk) disable iff (!rst_b)
    (wr.en && wr.addr == OFS_DISCHARGE) |=> ##1
      ch_running.ch5 || pd_q.ch5 == $past(wr.data[DIS_CH5_POS], 2))
    else $error("discharge write not applied");
  a_ch2_delay_exact: assert property (
    @(posedge mclk) disable iff (!rst_b)
    $rose(on_q[0]) |-> elapsed_q[0] == dly_cycles(code_lat_q[0]) + DLY_CNT_W'(1))
    else $error("ch2 turn-on delay wrong");
  a_ch3_delay_exact: assert property (
    @(posedge mclk) disable iff (!rst_b)
    $rose(on_q[1]) |-> elapsed_q[1] == dly_cycles(code_lat_q[1]) + DLY_CNT_W'(1))
    else $error("ch3 turn-on delay wrong");
  a_zero_code_immediate: assert property (
    @(posedge mclk) disable iff (!rst_b)
    (pst_q[1] == PWR_OFF && ch3_on_req && ch3_turn_on_delay_code_q == 4'h0) |=> ch3_enable)
    else $error("ch3 zero delay not immediate");

endmodule

/* File: common/pmic_cfg_pkg.sv */
/*
  Shared constants and types for the output discharge and power-on delay
  register bank. Assumes a 200 MHz core clock and 8-bit registers behind
  a two-wire serial slave.
*/
package pmic_cfg_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_DISCHARGE  = 8'h06;
  localparam logic [7:0] OFS_LED_OVP    = 8'h07;
  localparam logic [7:0] OFS_SPARE      = 8'h08;
  localparam logic [7:0] OFS_ON_DLY_3_2 = 8'h09;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int DIS_CH10_POS = 5;
  localparam int DIS_CH5_POS  = 4;
  localparam int DIS_CH4_POS  = 3;
  localparam int DIS_CH3_POS  = 2;
  localparam int OVP_LSB      = 0;
  localparam int OVP_W        = 3;
  localparam int DLY_CH2_LSB  = 0;
  localparam int DLY_CH3_LSB  = 4;
  localparam int DLY_W        = 4;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_DISCHARGE = 8'h1c;
  localparam logic [7:0] RST_LED_OVP   = 8'h06;
  localparam logic [7:0] RST_SPARE     = 8'h00;
  // On-delay preset per power sequence selection
  localparam logic [7:0] RST_ON_DLY_SEQ [4] = '{8'h00, 8'h12, 8'h24, 8'h48};

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_KHZ      = 200000;
  localparam int DLY_UNIT_MS  = 2;
  localparam int DLY_UNIT_CYC = DLY_UNIT_MS * CLK_KHZ;
  localparam int DLY_CNT_W    = 24;

  // Serial slave address (arbitrary value)
  localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h2a;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {PWR_OFF, PWR_WAIT, PWR_ON} pwr_e;

  typedef struct packed {
    logic       en;
    logic [7:0] addr;
    logic [7:0] data;
  } reg_wr_s;

  typedef struct packed {
    logic ch10;
    logic ch5;
    logic ch4;
    logic ch3;
  } disch_s;

endpackage

/* File: hw/serial_reg_slave.sv */
/*
  Two-wire serial slave: pointer write, data writes and reads with auto
  increment. Assumes scl and sda are synchronous to mclk and that read
  data for the current pointer is available combinationally.
*/
module serial_reg_slave
  import pmic_cfg_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = DEV_ADDR_DEFAULT
)
(
  // Clock and reset
  input  wire logic                 mclk,
  input  wire logic                 rst_b,
  // Serial pins
  input  wire logic                 scl_i,
  input  wire logic                 sda_i,
  output      logic                 sda_o,
  output      logic                 sda_oe,
  // Register side
  output      pmic_cfg_pkg::reg_wr_s wr,
  output      logic [7:0]           rd_addr,
  input  wire logic [7:0]           rd_data
);
  import pmic_cfg_pkg::*;

  typedef enum logic [2:0] {S_IDLE, S_RX, S_ACK, S_TX, S_TXACK} ser_e;
  typedef enum logic [1:0] {PH_ADDR, PH_PTR, PH_DATA} phase_e;

  ser_e       st_q;
  phase_e     ph_q;
  logic       scl_q;
  logic       sda_q;
  logic [7:0] sh_q;
  logic [2:0] cnt_q;
  logic       got_q;
  logic       rw_q;
  logic       mack_q;
  logic [7:0] ptr_q;
  logic       oe_q;
  reg_wr_s    wr_q;

  logic scl_rise;
  logic scl_fall;
  logic start_c;
  logic stop_c;

  assign scl_rise = scl_i & ~scl_q;
  assign scl_fall = ~scl_i & scl_q;
  assign start_c  = scl_i & scl_q & sda_q & ~sda_i;
  assign stop_c   = scl_i & scl_q & ~sda_q & sda_i;

  assign sda_o   = 1'b0;
  assign sda_oe  = oe_q;
  assign wr      = wr_q;
  assign rd_addr = ptr_q;

  // ----------------------------------------------------------------
  // Pin history
  // ----------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    scl_q <= scl_i;
    sda_q <= sda_i;
  end

  // ----------------------------------------------------------------
  // Protocol engine
  // ----------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    wr_q.en <= 1'b0;
    if (!rst_b)
    begin
      st_q   <= S_IDLE;
      ph_q   <= PH_ADDR;
      sh_q   <= 8'h00;
      cnt_q  <= 3'h0;
      got_q  <= 1'b0;
      rw_q   <= 1'b0;
      mack_q <= 1'b0;
      ptr_q  <= 8'h00;
      oe_q   <= 1'b0;
      wr_q   <= '0;
    end
    else if (start_c)
    begin
      st_q  <= S_RX;
      ph_q  <= PH_ADDR;
      cnt_q <= 3'h0;
      got_q <= 1'b0;
      oe_q  <= 1'b0;
    end
    else if (stop_c)
    begin
      st_q <= S_IDLE;
      oe_q <= 1'b0;
    end
    else
    begin
      unique case (st_q)
        S_IDLE: ;
        S_RX:
          if (scl_rise)
          begin
            sh_q  <= {sh_q[6:0], sda_i};
            cnt_q <= cnt_q + 3'h1;
            got_q <= (cnt_q == 3'h7);
          end
          else if (scl_fall && got_q)
          begin
            got_q <= 1'b0;
            st_q  <= S_ACK;
            oe_q  <= 1'b1;
            unique case (ph_q)
              PH_ADDR:
                if (sh_q[7:1] == DEV_ADDR)
                  rw_q <= sh_q[0];
                else
                begin
                  st_q <= S_IDLE;
                  oe_q <= 1'b0;
                end
              PH_PTR:  ptr_q <= sh_q;
              PH_DATA:
              begin
                wr_q  <= '{en: 1'b1, addr: ptr_q, data: sh_q};
                ptr_q <= ptr_q + 8'h01;
              end
            endcase
          end
        S_ACK:
          if (scl_fall)
          begin
            cnt_q <= 3'h0;
            if (ph_q == PH_ADDR && rw_q)
            begin
              sh_q <= {rd_data[6:0], 1'b0};
              oe_q <= ~rd_data[7];
              st_q <= S_TX;
            end
            else
            begin
              oe_q <= 1'b0;
              st_q <= S_RX;
              ph_q <= (ph_q == PH_ADDR) ? PH_PTR : PH_DATA;
            end
          end
        S_TX:
          if (scl_fall)
          begin
            cnt_q <= cnt_q + 3'h1;
            if (cnt_q == 3'h7)
            begin
              oe_q  <= 1'b0;
              ptr_q <= ptr_q + 8'h01;
              st_q  <= S_TXACK;
            end
            else
            begin
              oe_q <= ~sh_q[7];
              sh_q <= {sh_q[6:0], 1'b0};
            end
          end
        S_TXACK:
          if (scl_rise)
            mack_q <= ~sda_i;
          else if (scl_fall)
          begin
            cnt_q <= 3'h0;
            if (mack_q)
            begin
              sh_q <= {rd_data[6:0], 1'b0};
              oe_q <= ~rd_data[7];
              st_q <= S_TX;
            end
            else
              st_q <= S_IDLE;
          end
        default: st_q <= S_IDLE;
      endcase
    end
  end

endmodule

/* File: verification/serial_host_model.sv */
/*
  Behavioural host on the two-wire serial pins: start, stop and byte
  transfers, four mclk per scl phase. Assumes the bench resolves the
  open-drain data wire with a pull-up and feeds it back on sda_wire.
*/
module serial_host_model
(
  // Clock
  input  wire logic mclk,
  // Serial pins
  output      logic scl,
  output      logic sda_pull,
  input  wire logic sda_wire
);
  timeunit 1ns;
  timeprecision 100ps;

  initial
  begin
    scl      = 1'b1;
    sda_pull = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  // Data set while scl is low, wire sampled just before scl falls
  task automatic bit_io(input logic b, output logic r);
    sda_pull = ~b;
    tick(4);
    scl = 1'b1;
    tick(4);
    r   = sda_wire;
    scl = 1'b0;
  endtask

  // Also serves as repeated start after an acknowledge
  task automatic start_cond();
    sda_pull = 1'b0;
    tick(4);
    scl = 1'b1;
    tick(4);
    sda_pull = 1'b1;
    tick(4);
    scl = 1'b0;
  endtask

  task automatic stop_cond();
    sda_pull = 1'b1;
    tick(4);
    scl = 1'b1;
    tick(4);
    sda_pull = 1'b0;
    tick(4);
  endtask

  task automatic send_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = ~r;
  endtask

  // last high sends the closing not-acknowledge
  task automatic recv_byte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(last, r);
  endtask
endmodule

/* File: verification/pmic_output_discharge_config_tb.sv */
/*
  Self-checking bench for the discharge and power-on delay registers.
  Assumes the serial host model and a pulled-up open-drain data wire.
*/
module pmic_output_discharge_config_tb;
  import pmic_cfg_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;

  localparam int UNIT = 4;

  logic       mclk = 1'b0;
  logic       rst_b = 1'b0;
  logic       scl, sda_pull, sda_wire, sda_o, sda_oe;
  logic [1:0] sel;
  disch_s     ch_running;
  disch_s     ch_pulldown;
  logic       ch3_on_req;
  logic       ch2_on_req;
  logic       ch3_enable, ch2_enable;
  logic [2:0] ovp_code;
  int         n_errors = 0;
  int         checked = 0;

  always #2.5 mclk = ~mclk;
  assign sda_wire = (sda_pull || (sda_oe && !sda_o)) ? 1'b0 : 1'b1;

  pmic_output_discharge_config #(.DELAY_UNIT_CYCLES(UNIT), .DEV_ADDR(DEV_ADDR_DEFAULT))
    pmic_output_discharge_config_i (.mclk(mclk), .rst_b(rst_b), .scl_i(scl),
    .sda_i(sda_wire), .sda_o(sda_o), .sda_oe(sda_oe),
    .power_sequence_selection(sel), .ch_running(ch_running), .ch3_on_req(ch3_on_req),
    .ch2_on_req(ch2_on_req), .ch_pulldown(ch_pulldown), .ch3_enable(ch3_enable),
    .ch2_enable(ch2_enable), .led_boost_overvoltage_code(ovp_code));

  serial_host_model serial_host_model_i (.mclk(mclk), .scl(scl), .sda_pull(sda_pull),
    .sda_wire(sda_wire));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic do_reset(input logic [1:0] s);
    sel   = s;
    rst_b = 1'b0;
    repeat (4) @(posedge mclk);
    #1;
    rst_b = 1'b1;
  endtask

  task automatic reg_write(input logic [7:0] ofs, input logic [7:0] d);
    logic a0, a1, a2;
    serial_host_model_i.start_cond();
    serial_host_model_i.send_byte({DEV_ADDR_DEFAULT, 1'b0}, a0);
    serial_host_model_i.send_byte(ofs, a1);
    serial_host_model_i.send_byte(d, a2);
    serial_host_model_i.stop_cond();
    check("write ack", {5'h0, a0, a1, a2}, 8'h07);
  endtask

  task automatic reg_read(input logic [7:0] ofs, output logic [7:0] d);
    logic a0, a1, a2;
    serial_host_model_i.start_cond();
    serial_host_model_i.send_byte({DEV_ADDR_DEFAULT, 1'b0}, a0);
    serial_host_model_i.send_byte(ofs, a1);
    serial_host_model_i.start_cond();
    serial_host_model_i.send_byte({DEV_ADDR_DEFAULT, 1'b1}, a2);
    serial_host_model_i.recv_byte(1'b1, d);
    serial_host_model_i.stop_cond();
    check("read ack", {5'h0, a0, a1, a2}, 8'h07);
  endtask

  // Edges after the request edge until each enable is first seen high
  task automatic wait_enables(output int k3, output int k2);
    k3 = 0;
    k2 = 0;
    @(posedge mclk);
    for (int k = 1; k < 100 && (k3 == 0 || k2 == 0); k++)
    begin
      @(posedge mclk);
      #1;
      if (k3 == 0 && ch3_enable === 1'b1)
        k3 = k;
      if (k2 == 0 && ch2_enable === 1'b1)
        k2 = k;
    end
    if (k3 == 0 || k2 == 0)
    begin
      check("enable wait", 8'h00, 8'h01);
      give_verdict();
    end
  endtask

  function automatic logic [7:0] dly(input logic [3:0] c);
    return (c == 4'h0) ? 8'h01 : 8'(c * UNIT);
  endfunction

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic test_reset_values();
    logic [7:0] d;
    for (int s = 0; s < 4; s++)
    begin
      do_reset(2'(s));
      reg_read(OFS_ON_DLY_3_2, d);
      check("delay preset", d, RST_ON_DLY_SEQ[s]);
    end
    check("pulldown after reset", {4'h0, ch_pulldown}, 8'h07);
    reg_read(OFS_DISCHARGE, d);
    check("discharge reset", d, 8'h1c);
    reg_read(OFS_LED_OVP, d);
    check("ovp reset", d, 8'h06);
    $display("test reset values done");
  endtask

  task automatic test_discharge();
    logic [7:0] wv [5] = '{8'hff, 8'h20, 8'h10, 8'h0c, 8'hff};
    logic [3:0] rn [5] = '{4'h0, 4'h0, 4'ha, 4'h1, 4'hf};
    logic [7:0] d;
    for (int i = 0; i < 5; i++)
    begin
      ch_running = disch_s'(rn[i]);
      reg_write(OFS_DISCHARGE, wv[i]);
      serial_host_model_i.tick(2);
      check("pulldown", {4'h0, ch_pulldown}, {4'h0, wv[i][5:2] & ~rn[i]});
    end
    ch_running = disch_s'(4'h0);
    serial_host_model_i.tick(2);
    check("pulldown on stop", {4'h0, ch_pulldown}, 8'h0f);
    reg_read(OFS_DISCHARGE, d);
    check("discharge readback", d, 8'h3c);
    $display("test discharge done");
  endtask

  task automatic test_regs();
    logic [7:0] d;
    logic       a;
    for (int c = 0; c < 8; c++)
    begin
      reg_write(OFS_LED_OVP, 8'(c) | 8'hf8);
      reg_read(OFS_LED_OVP, d);
      check("ovp readback", d, 8'(c));
      check("ovp output", {5'h0, ovp_code}, 8'(c));
    end
    reg_write(OFS_SPARE, 8'hff);
    reg_read(OFS_SPARE, d);
    check("spare readback", d, 8'h00);
    serial_host_model_i.start_cond();
    serial_host_model_i.send_byte({DEV_ADDR_DEFAULT ^ 7'h01, 1'b0}, a);
    serial_host_model_i.stop_cond();
    check("foreign address ack", {7'h0, a}, 8'h00);
    $display("test registers done");
  endtask

  task automatic test_delay();
    logic [7:0] codes [4] = '{8'hf0, 8'h1f, 8'h23, 8'h00};
    int k3, k2;
    for (int i = 0; i < 4; i++)
    begin
      reg_write(OFS_ON_DLY_3_2, codes[i]);
      ch3_on_req = 1'b1;
      ch2_on_req = 1'b1;
      wait_enables(k3, k2);
      check("ch3 delay", 8'(k3), dly(codes[i][7:4]));
      check("ch2 delay", 8'(k2), dly(codes[i][3:0]));
      ch3_on_req = 1'b0;
      ch2_on_req = 1'b0;
      serial_host_model_i.tick(1);
      check("enables drop", {6'h0, ch3_enable, ch2_enable}, 8'h00);
    end
    $display("test delay done");
  endtask

  task automatic test_abort();
    logic seen;
    int   k3, k2;
    reg_write(OFS_ON_DLY_3_2, 8'h22);
    ch3_on_req = 1'b1;
    serial_host_model_i.tick(4);
    ch3_on_req = 1'b0;
    seen = 1'b0;
    for (int k = 0; k < 12; k++)
    begin
      serial_host_model_i.tick(1);
      seen = seen | ch3_enable;
    end
    check("aborted enable", {7'h0, seen}, 8'h00);
    ch3_on_req = 1'b1;
    ch2_on_req = 1'b1;
    wait_enables(k3, k2);
    check("restart delay", 8'(k3), dly(4'h2));
    check("restart ch2 delay", 8'(k2), dly(4'h2));
    ch3_on_req = 1'b0;
    ch2_on_req = 1'b0;
    serial_host_model_i.tick(1);
    $display("test abort done");
  endtask

  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial
  begin
    ch_running = '0;
    ch3_on_req = 1'b0;
    ch2_on_req = 1'b0;
    do_reset(2'h0);
    test_reset_values();
    test_discharge();
    test_regs();
    test_delay();
    test_abort();
    give_verdict();
  end

  initial
  begin
    repeat (100000) @(posedge mclk);
    n_errors++;
    give_verdict();
  end
endmodule
